// *** rtl/timer_block.sv ***
/*
  timer_block: two legacy counter/timers (13-bit, 16-bit and 8-bit
  auto-reload modes with external gating) and a third 16/8-bit timer,
  all behind a classic wishbone slave.
  assumes tick_i is a one-cycle enable from a system prescaler and that
  gate inputs are synchronous to clk_i.
*/
// Overview of operation
// - mode 1 counts the full sixteen bit pair as one counter.
// - mode 2 counts in the low byte; the high byte holds reload.
// - low byte rolling from all ones sets overflow and reloads it.
// - enabled overflow flag raises the interrupt request.
// - reload byte is never changed by the reload itself.
// - second legacy timer behaves identically with its own resources.
// - run bit counts when ungated, or gated while external input active.
// - external input active level chosen by a software polarity bit.
// - timer 3 low byte is count low or independent 8-bit count.
// - timer 3 high byte is count high or its own 8-bit count.
`timescale 1ns/1ns
module timer_block
  import timer_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        tick_i,
  input  wire logic        gate_a_i,
  input  wire logic        gate_b_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [9:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  output logic             err_o,
  output logic             irq_o
);

  //////////////////////////////////////////////////////////////////////////
  // state
  logic [7:0] ctrl, mode, extcfg, t3ctrl;
  logic [7:0] ta_lo, ta_hi, tb_lo, tb_hi, t3_lo, t3_hi;
  logic [IRQ_N-1:0] irq_stat, irq_en;
  logic [7:0] next_ctrl, next_mode, next_extcfg, next_t3ctrl;
  logic [7:0] next_ta_lo, next_ta_hi, next_tb_lo, next_tb_hi;
  logic [7:0] next_t3_lo, next_t3_hi;
  logic [IRQ_N-1:0] next_irq_stat, next_irq_en;
  logic [31:0] next_dat;
  logic        next_ack, next_err, next_irq;

  // one legacy timer step: returns {ovf, hi, lo}
  function automatic logic [16:0] legacy_step(
    input logic [1:0] md,
    input logic [7:0] lo,
    input logic [7:0] hi
  );
    logic [15:0] cnt;
    logic [16:0] r;
    cnt = 16'h0000;
    r   = {1'b0, hi, lo};
    unique case (md)
      MODE_13BIT: begin
        r[4:0] = lo[4:0] + 5'h01;
        if (lo[4:0] == LOW5_ONES) begin
          r[15:8] = hi + 8'h01;
          r[16]   = (hi == ALL_ONES);
        end
      end
      MODE_16BIT: begin
        cnt = {hi, lo} + 16'h0001;
        r   = {({hi, lo} == 16'hFFFF), cnt};
      end
      MODE_RELOAD: begin
        r[7:0] = (lo == ALL_ONES) ? hi : lo + 8'h01;
        r[16]  = (lo == ALL_ONES);
        r[15:8] = hi;
      end
      default: r = {1'b0, hi, lo};  // mode 3 halts only the timer that selects it
    endcase
    return r;
  endfunction : legacy_step

  // counting enable with optional gating
  function automatic logic run_ok(
    input logic run,
    input logic gate_sel,
    input logic gate_in,
    input logic pol
  );
    return run && (!gate_sel || (gate_in == pol));
  endfunction : run_ok

  function automatic logic [7:0] wr_byte(
    input logic [7:0] old,
    input logic       en,
    input logic [7:0] d
  );
    return en ? d : old;
  endfunction : wr_byte

  //////////////////////////////////////////////////////////////////////////
  // bus decode
  logic        req, wr, lane0;
  logic [7:0]  widx, wd;
  logic        hit;
  logic [16:0] sa, sb;
  logic        en_a, en_b, en_t3;
  logic [15:0] t3_sum;
  logic [7:0]  t3l_inc, t3h_inc;
  logic [IRQ_N-1:0] ev;
  logic        wr_a, wr_b, wr_t3;
  logic        step_a, step_b, step_t3;

  assign req   = cyc_i && stb_i && !ack_o && !err_o;
  assign wr    = req && we_i;
  assign lane0 = sel_i[0];
  assign widx  = adr_i[9:2];
  assign wd    = dat_i[7:0];

  always_comb begin
    unique case (widx)
      IDX_CTRL, IDX_MODE, IDX_EXTCFG, IDX_TA_LOW, IDX_TA_HIGH,
      IDX_TB_LOW, IDX_TB_HIGH, IDX_T3_CTRL, IDX_T3_LOW, IDX_T3_HIGH,
      IDX_IRQ_STAT, IDX_IRQ_EN, IDX_IRQ_CLR: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // timer arithmetic
  assign sa = legacy_step(mode[MODE_A_LSB +: 2], ta_lo, ta_hi);
  assign sb = legacy_step(mode[MODE_B_LSB +: 2], tb_lo, tb_hi);
  assign en_a = tick_i && run_ok(ctrl[CTRL_A_RUN],
                                 mode[MODE_A_LSB + MODE_GATE],
                                 gate_a_i, extcfg[EXT_A_POL]);
  assign en_b = tick_i && run_ok(ctrl[CTRL_B_RUN],
                                 mode[MODE_B_LSB + MODE_GATE],
                                 gate_b_i, extcfg[EXT_B_POL]);
  assign en_t3   = tick_i && t3ctrl[T3_RUN];
  assign t3_sum  = {t3_hi, t3_lo} + 16'h0001;
  assign t3l_inc = t3_lo + 8'h01;
  assign t3h_inc = t3_hi + 8'h01;

  // a count write wins its cycle; step and flag are dropped together
  // so a flag never appears without the reload that goes with it
  assign wr_a    = wr && lane0
                   && (widx == IDX_TA_LOW || widx == IDX_TA_HIGH);
  assign wr_b    = wr && lane0
                   && (widx == IDX_TB_LOW || widx == IDX_TB_HIGH);
  assign wr_t3   = wr && lane0
                   && (widx == IDX_T3_LOW || widx == IDX_T3_HIGH);
  assign step_a  = en_a && !wr_a;
  assign step_b  = en_b && !wr_b;
  assign step_t3 = en_t3 && !wr_t3;

  always_comb begin
    ev = '0;
    ev[IRQ_A] = step_a && sa[16];
    ev[IRQ_B] = step_b && sb[16];
    if (t3ctrl[T3_SPLIT]) begin
      ev[IRQ_T3L] = step_t3 && (t3_lo == ALL_ONES);
      ev[IRQ_T3H] = step_t3 && (t3_hi == ALL_ONES);
    end else begin
      ev[IRQ_T3H] = step_t3 && ({t3_hi, t3_lo} == 16'hFFFF);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    next_ctrl     = ctrl;
    next_mode     = mode;
    next_extcfg   = extcfg;
    next_t3ctrl   = t3ctrl;
    next_ta_lo    = ta_lo;
    next_ta_hi    = ta_hi;
    next_tb_lo    = tb_lo;
    next_tb_hi    = tb_hi;
    next_t3_lo    = t3_lo;
    next_t3_hi    = t3_hi;
    next_irq_en   = irq_en;
    next_irq_stat = irq_stat;

    // software writes first; flag events below win over them
    if (wr && lane0) begin
      unique case (widx)
        IDX_CTRL:    next_ctrl   = wd;
        IDX_MODE:    next_mode   = wd;
        IDX_EXTCFG:  next_extcfg = wd;
        IDX_T3_CTRL: next_t3ctrl = wd;
        IDX_TA_LOW:  next_ta_lo  = wd;
        IDX_TA_HIGH: next_ta_hi  = wd;
        IDX_TB_LOW:  next_tb_lo  = wd;
        IDX_TB_HIGH: next_tb_hi  = wd;
        IDX_T3_LOW:  next_t3_lo  = wd;
        IDX_T3_HIGH: next_t3_hi  = wd;
        IDX_IRQ_EN:  next_irq_en = wd[IRQ_N-1:0];
        IDX_IRQ_CLR: next_irq_stat = irq_stat & ~wd[IRQ_N-1:0];
        default: ;
      endcase
    end

    // count update skipped on the write cycle of the same timer
    if (step_a) begin
      next_ta_lo = sa[7:0];
      next_ta_hi = sa[15:8];
    end
    if (step_b) begin
      next_tb_lo = sb[7:0];
      next_tb_hi = sb[15:8];
    end
    if (step_t3) begin
      if (t3ctrl[T3_SPLIT]) begin
        next_t3_lo = t3l_inc;
        next_t3_hi = t3h_inc;
      end else begin
        next_t3_lo = t3_sum[7:0];
        next_t3_hi = t3_sum[15:8];
      end
    end

    // sticky flags: set beats a same-cycle clear
    if (ev[IRQ_A])   next_ctrl[CTRL_A_OVF]  = 1'b1;
    if (ev[IRQ_B])   next_ctrl[CTRL_B_OVF]  = 1'b1;
    if (ev[IRQ_T3L]) next_t3ctrl[T3_OVF_LO] = 1'b1;
    if (ev[IRQ_T3H]) next_t3ctrl[T3_OVF_HI] = 1'b1;
    next_irq_stat = next_irq_stat | ev;
  end

  //////////////////////////////////////////////////////////////////////////
  // bus answer and interrupt
  always_comb begin
    next_dat = 32'h0000_0000;
    next_ack = req && hit;
    next_err = req && !hit;      // unmapped address answers with err
    if (req && !we_i) begin
      unique case (widx)
        IDX_CTRL:     next_dat[7:0] = ctrl;
        IDX_MODE:     next_dat[7:0] = mode;
        IDX_EXTCFG:   next_dat[7:0] = extcfg;
        IDX_T3_CTRL:  next_dat[7:0] = t3ctrl;
        IDX_TA_LOW:   next_dat[7:0] = ta_lo;
        IDX_TA_HIGH:  next_dat[7:0] = ta_hi;
        IDX_TB_LOW:   next_dat[7:0] = tb_lo;
        IDX_TB_HIGH:  next_dat[7:0] = tb_hi;
        IDX_T3_LOW:   next_dat[7:0] = t3_lo;
        IDX_T3_HIGH:  next_dat[7:0] = t3_hi;
        IDX_IRQ_STAT: next_dat[IRQ_N-1:0] = irq_stat;
        IDX_IRQ_EN:   next_dat[IRQ_N-1:0] = irq_en;
        default: ;
      endcase
    end
    // built from the next flags so the level moves with them
    next_irq = |(next_irq_stat & next_irq_en);
  end

  //////////////////////////////////////////////////////////////////////////
  // timer and register state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl     <= RESET_BYTE;
      mode     <= RESET_BYTE;
      extcfg   <= RESET_BYTE;
      t3ctrl   <= RESET_BYTE;
      ta_lo    <= RESET_BYTE;
      ta_hi    <= RESET_BYTE;
      tb_lo    <= RESET_BYTE;
      tb_hi    <= RESET_BYTE;
      t3_lo    <= RESET_BYTE;
      t3_hi    <= RESET_BYTE;
      irq_stat <= '0;
      irq_en   <= '0;
    end else begin
      ctrl     <= next_ctrl;
      mode     <= next_mode;
      extcfg   <= next_extcfg;
      t3ctrl   <= next_t3ctrl;
      ta_lo    <= next_ta_lo;
      ta_hi    <= next_ta_hi;
      tb_lo    <= next_tb_lo;
      tb_hi    <= next_tb_hi;
      t3_lo    <= next_t3_lo;
      t3_hi    <= next_t3_hi;
      irq_stat <= next_irq_stat;
      irq_en   <= next_irq_en;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // registered bus answer and interrupt level
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o    <= 32'h0000_0000;
      ack_o    <= 1'b0;
      err_o    <= 1'b0;
      irq_o    <= 1'b0;
    end else begin
      dat_o    <= next_dat;
      ack_o    <= next_ack;
      err_o    <= next_err;
      irq_o    <= next_irq;
    end
  end

endmodule : timer_block

// *** rtl/timer_pkg.sv ***
/*
  timer_pkg: register offsets, field positions, reset values and mode
  codes shared by the timer block.
  assumes a classic wishbone slave with 32-bit data, word aligned.
*/
package timer_pkg;

  //////////////////////////////////////////////////////////////////////////
  // register word indices (byte offset of each register is index * 4)
  localparam logic [7:0] IDX_T3_LOW   = 8'h94;
  localparam logic [7:0] IDX_T3_HIGH  = 8'h95;
  localparam logic [7:0] IDX_CTRL     = 8'h00;
  localparam logic [7:0] IDX_MODE     = 8'h01;
  localparam logic [7:0] IDX_EXTCFG   = 8'h02;
  localparam logic [7:0] IDX_TA_LOW   = 8'h03;
  localparam logic [7:0] IDX_TA_HIGH  = 8'h04;
  localparam logic [7:0] IDX_TB_LOW   = 8'h05;
  localparam logic [7:0] IDX_TB_HIGH  = 8'h06;
  localparam logic [7:0] IDX_T3_CTRL  = 8'h07;
  localparam logic [7:0] IDX_IRQ_STAT = 8'h08;
  localparam logic [7:0] IDX_IRQ_EN   = 8'h09;
  localparam logic [7:0] IDX_IRQ_CLR  = 8'h0A;

  //////////////////////////////////////////////////////////////////////////
  // control register fields
  localparam int CTRL_A_RUN  = 4;
  localparam int CTRL_A_OVF  = 5;
  localparam int CTRL_B_RUN  = 6;
  localparam int CTRL_B_OVF  = 7;
  // mode register: timer a in [3:0], timer b in [7:4]
  localparam int MODE_A_LSB  = 0;
  localparam int MODE_B_LSB  = 4;
  localparam int MODE_GATE   = 3;
  // ext config: polarity of each gate input
  localparam int EXT_A_POL   = 3;
  localparam int EXT_B_POL   = 7;
  // timer 3 control
  localparam int T3_RUN      = 2;
  localparam int T3_SPLIT    = 3;
  localparam int T3_OVF_HI   = 7;
  localparam int T3_OVF_LO   = 6;

  localparam logic [1:0] MODE_13BIT  = 2'h0;
  localparam logic [1:0] MODE_16BIT  = 2'h1;
  localparam logic [1:0] MODE_RELOAD = 2'h2;

  localparam logic [7:0] RESET_BYTE  = 8'h00;
  localparam logic [7:0] ALL_ONES    = 8'hFF;
  localparam logic [4:0] LOW5_ONES   = 5'h1F;

  // interrupt status bit layout
  localparam int IRQ_A   = 0;
  localparam int IRQ_B   = 1;
  localparam int IRQ_T3L = 2;
  localparam int IRQ_T3H = 3;
  localparam int IRQ_N   = 4;

endpackage : timer_pkg

// *** test/timer_block_bench.sv ***
/* timer_block_bench: directed tests of timer_block over wishbone.
   assumes 25 MHz clock and sync active-high reset. */
`timescale 1ns/1ns
module timer_block_bench import timer_pkg::*;;
  logic        clk, rst, tick, ga, gb, cyc, stb, we, ack, err, irq, e;
  logic [9:0]  adr;
  logic [31:0] wdat, rdat, q;
  int          n_fail = 0;
  int          check_count = 0;
  timer_block u_timer_block (.clk_i(clk), .rst_i(rst), .tick_i(tick),
    .gate_a_i(ga), .gate_b_i(gb), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(4'hF), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
    .err_o(err), .irq_o(irq));
  initial begin
    clk = 0;
    forever #20 clk = ~clk;
  end
  //////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish;
    if (n_fail == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [31:0] got, exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // holds the request until ack or err is sampled high
  // no timeout of its own: only the watchdog ends a wait with no answer
  task automatic bus(input logic w, input logic [7:0] i, d);
    @(posedge clk);
    cyc  <= 1;
    stb  <= 1;
    we   <= w;
    adr  <= {i, 2'b00};
    wdat <= {24'h00_0000, d};
    do begin
      @(posedge clk);
    end while (ack !== 1'b1 && err !== 1'b1);
    q = rdat;
    e = err;
    cyc <= 0;
    stb <= 0;
  endtask : bus
  task automatic wr(input logic [7:0] i, d);
    bus(1, i, d);
  endtask : wr
  task automatic rd(input logic [7:0] i, input logic [31:0] x);
    bus(0, i, 8'h00);
    chk(q, x);
  endtask : rd
  // irq is registered: let one edge land before looking
  task automatic irq_is(input logic x);
    @(posedge clk);
    chk(32'(irq), 32'(x));
  endtask : irq_is
  task automatic ticks(input int k);
    repeat (k) begin
      @(posedge clk);
      tick <= 1;
      @(posedge clk);
      tick <= 0;
    end
  endtask : ticks
  //////////////////////////////////////////////////////////////////////////
  task automatic t_reload(input int t);
    logic [7:0] b;
    b = 8'(t * 2);
    wr(IDX_MODE, {6'h00, MODE_RELOAD} << (4 * t));
    wr(IDX_TA_HIGH + b, 8'hA5);
    wr(IDX_TA_LOW + b, 8'hFE);
    wr(IDX_IRQ_EN, 8'(1 << t));
    wr(IDX_CTRL, 8'(1 << (4 + b)));
    ticks(2);
    rd(IDX_TA_LOW + b, 8'hA5);
    rd(IDX_TA_HIGH + b, 8'hA5);
    ticks(1);
    rd(IDX_TA_LOW + b, 8'hA6);
    rd(IDX_CTRL, 8'(8'h30 << b));
    rd(IDX_IRQ_STAT, 8'(1 << t));
    irq_is(1);
    wr(IDX_IRQ_EN, 8'h00);
    irq_is(0);
    wr(IDX_IRQ_EN, 8'(1 << t));
    irq_is(1);
    wr(IDX_IRQ_CLR, 8'(1 << t));
    irq_is(0);
    wr(IDX_CTRL, 8'h00);
  endtask : t_reload
  task automatic t_wide;
    wr(IDX_MODE, 8'(MODE_16BIT));
    wr(IDX_TA_LOW, 8'hFF);
    wr(IDX_TA_HIGH, 8'h12);
    wr(IDX_CTRL, 8'h10);
    ticks(1);
    rd(IDX_TA_LOW, 8'h00);
    rd(IDX_TA_HIGH, 8'h13);
    wr(IDX_TA_LOW, 8'hFF);
    wr(IDX_TA_HIGH, 8'hFF);
    ticks(1);
    rd(IDX_TA_HIGH, 8'h00);
    rd(IDX_CTRL, 8'h30);
    wr(IDX_CTRL, 8'h00);
    wr(IDX_IRQ_CLR, 8'h0F);
  endtask : t_wide
  task automatic t_short;
    wr(IDX_MODE, {6'h00, MODE_13BIT});
    wr(IDX_TA_LOW, 8'h1F);
    wr(IDX_TA_HIGH, 8'h07);
    wr(IDX_CTRL, 8'h10);
    ticks(1);
    rd(IDX_TA_LOW, 8'h00);
    rd(IDX_TA_HIGH, 8'h08);
    wr(IDX_CTRL, 8'h00);
  endtask : t_short
  task automatic t_gate(input int t, input logic p);
    logic [7:0] b;
    b = 8'(t * 2);
    wr(IDX_EXTCFG, {4'h0, p, 3'h0} << (4 * t));
    wr(IDX_MODE, 8'h0A << (4 * t));
    wr(IDX_TA_LOW + b, 8'h10);
    wr(IDX_CTRL, 8'h10 << b);
    if (t == 0) ga <= !p;
    else gb <= !p;
    ticks(1);
    rd(IDX_TA_LOW + b, 8'h10);
    if (t == 0) ga <= p;
    else gb <= p;
    ticks(1);
    rd(IDX_TA_LOW + b, 8'h11);
    wr(IDX_CTRL, 8'h00);
  endtask : t_gate
  task automatic t_three;
    wr(IDX_T3_LOW, 8'hFF);
    wr(IDX_T3_HIGH, 8'h05);
    wr(IDX_T3_CTRL, 8'h04);
    ticks(1);
    rd(IDX_T3_LOW, 8'h00);
    rd(IDX_T3_HIGH, 8'h06);
    wr(IDX_T3_CTRL, 8'h0C);
    wr(IDX_T3_LOW, 8'hFF);
    ticks(1);
    rd(IDX_T3_LOW, 8'h00);
    rd(IDX_IRQ_STAT, 8'h04);
    rd(IDX_T3_HIGH, 8'h07);
    wr(IDX_T3_HIGH, 8'hFF);
    ticks(1);
    rd(IDX_T3_HIGH, 8'h00);
    rd(IDX_T3_LOW, 8'h01);
    rd(IDX_IRQ_STAT, 8'h0C);
  endtask : t_three
  //////////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1;
    {tick, ga, gb, cyc, stb, we} = '0;
    adr = '0;
    wdat = '0;
    repeat (12) @(posedge clk);
    rst <= 0;
    rd(IDX_T3_LOW, 8'h00);
    rd(IDX_T3_HIGH, 8'h00);
    bus(0, 8'h20, 8'h00);
    chk(32'(e), 1);
    for (int t = 0; t < 2; t++) t_reload(t);
    t_wide();
    t_short();
    for (int t = 0; t < 2; t++) begin
      t_gate(t, 1);
      t_gate(t, 0);
    end
    t_three();
    tally_and_finish();
  end
  initial begin
    repeat (5000) @(posedge clk);
    n_fail++;
    tally_and_finish();
  end
endmodule : timer_block_bench

// *** test/timer_props.sv ***
/* timer_props: port checker for timer_block.
   assumes one clock and a sync active-high reset. */
`timescale 1ns/1ns
module timer_props
  import timer_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        tick_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [9:0]  adr_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  input wire logic        err_o,
  input wire logic        irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic [7:0] ix;
  logic       req;
  logic       mp;
  assign ix  = adr_i[9:2];
  assign req = cyc_i && stb_i && !ack_o && !err_o;
  assign mp  = ix <= IDX_IRQ_CLR || ix == IDX_T3_LOW || ix == IDX_T3_HIGH;
  //////////////////////////////////////////////////////////////////////////
  ack_once_a: assert property (req |=> ack_o ^ err_o) else $error("no answer");
  ack_pulse_a: assert property (ack_o |=> !ack_o) else $error("ack held");
  ack_cause_a: assert property (ack_o |-> $past(req)) else $error("stray ack");
  err_unmapped_a: assert property (err_o |-> !$past(mp))
    else $error("bad err");
  ack_mapped_a: assert property (ack_o |-> $past(mp)) else $error("bad ack");
  high_zero_a: assert property (ack_o |-> dat_o[31:8] == 24'h00_0000)
    else $error("upper read bits set");
  clear_reads_zero_a: assert property (ack_o
    && $past(!we_i && ix == IDX_IRQ_CLR) |-> dat_o == 32'h0000_0000)
    else $error("clear index read nonzero");
  irq_rise_a: assert property ($rose(irq_o) |-> $past(tick_i) ||
    $past(cyc_i && we_i)) else $error("irq rose without cause");
  irq_fall_a: assert property ($fell(irq_o) |->
    $past(cyc_i && we_i)) else $error("irq fell without write");
  c_ack: cover property (ack_o);
  c_err: cover property (err_o);
  c_irq: cover property ($rose(irq_o));
endmodule : timer_props

bind timer_block timer_props u_timer_props (.clk_i, .rst_i, .tick_i,
  .cyc_i, .stb_i, .we_i, .adr_i, .dat_o, .ack_o, .err_o, .irq_o);
